/* File: verilog/angle_pkg.sv */
// What this block does
// - power-up runs one measurement, stores angle
// - power-up done asserts interrupt, then sleeps
// - reading angle over serial clears interrupt
// - read-angle command wakes, starts new measurement
// - result stored, interrupt and status flag set
// - command to interrupt within 320 to 430 us
// - one measurement per wake, then power down
// - sleep until next read request, no timer
// - active on-time taken as 600 us
// - interrupt active low, tri-state driven
// - angle bits 11:0, alarms above
// - read frame returns previously addressed data
// - parity over upper 15 bits, even frame
package angle_pkg;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_BITS = 14;
  localparam int ANGLE_BITS = 12;
  localparam int CNT_BITS = 5; // frame bit counter
  localparam int BIT_RW = 15; // 1 = read command
  localparam int BIT_EF = 1;
  localparam int BIT_PAR = 0;
  localparam logic [CNT_BITS-1:0] FRAME_LEN = 5'h10;
  // command addresses
  localparam logic [ADDR_BITS-1:0] ADDR_ANGLE = 14'h3fff;
  localparam logic [ADDR_BITS-1:0] ADDR_CLR_ERR = 14'h3380;
  localparam logic [ADDR_BITS-1:0] DATA_ZERO = 14'h0000;
  // timing, in microseconds at the clock rate in MHz
  localparam int CLK_MHZ = 200;
  localparam int T_CONV_MIN_US = 320;
  localparam int T_CONV_MAX_US = 430;
  localparam int T_MEAS_US = 375; // measurement time, inside the window
  localparam int T_ON_US = 600; // power-up plus first measurement
  // whole-cycle products, so rounding up and down agree
  localparam int CONV_MIN_CYC = T_CONV_MIN_US * CLK_MHZ;
  localparam int CONV_MAX_CYC = T_CONV_MAX_US * CLK_MHZ;
  localparam int MEAS_CYC = T_MEAS_US * CLK_MHZ;
  localparam int PWRUP_CYC = T_ON_US * CLK_MHZ;
  localparam int TIMER_BITS = 17; // holds the 600 us count
  // power states
  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_SLEEP,
    ST_MEAS
  } pwr_state_t;
endpackage

/* File: verilog/spi_frame_if.sv */
// frame events from the serial shifter to the control core
interface spi_frame_if;
  logic frame_start; // one-cycle pulse at select
  logic frame_end; // one-cycle pulse at deselect
  logic frame_full; // level: all frame bits clocked
  logic [angle_pkg::FRAME_BITS-1:0] rx_word; // last frame received
  logic [angle_pkg::FRAME_BITS-1:0] tx_word; // word to send next
  modport shifter(output frame_start, frame_end, frame_full, rx_word, input tx_word);
  modport core(input frame_start, frame_end, frame_full, rx_word, output tx_word);
endinterface

/* File: verilog/spi_frame_slave.sv */
module spi_frame_slave (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_b_o,
  spi_frame_if.shifter link
);
  import angle_pkg::*;

  logic [2:0] sck_s; // [0] is the synchroniser's first flop only
  logic [2:0] cs_s;
  logic [1:0] mosi_s;
  logic [FRAME_BITS-1:0] tx_sh_r; // outgoing shift register
  logic [FRAME_BITS-1:0] rx_sh_r; // incoming shift register
  logic [CNT_BITS-1:0] bits_r; // rising edges seen this frame
  logic miso_r;
  logic miso_oe_b_r;
  logic start_r;
  logic end_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic sel;

  // edges are taken from the second and third flops only
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign cs_fall = ~cs_s[1] & cs_s[2];
  assign cs_rise = cs_s[1] & ~cs_s[2];
  assign sel = ~cs_s[1];

  // pin synchronisers; the 48 ns link clock leaves ~5 samples per phase
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_s <= 3'h0;
      cs_s <= 3'h7;
      mosi_s <= 2'h0;
    end else if (en_i) begin
      sck_s <= {sck_s[1:0], sck_i};
      cs_s <= {cs_s[1:0], cs_b_i};
      mosi_s <= {mosi_s[0], mosi_i};
    end
  end

  // transmit side: load at select, shift on falling edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sh_r <= '0;
      miso_r <= 1'b0;
    end else if (en_i) begin
      if (cs_fall) begin
        tx_sh_r <= link.tx_word; // first bit ready before first rise
        miso_r <= link.tx_word[FRAME_BITS-1];
      end else if (sel && sck_fall) begin
        tx_sh_r <= {tx_sh_r[FRAME_BITS-2:0], 1'b0};
        miso_r <= tx_sh_r[FRAME_BITS-2];
      end
    end
  end

  // receive side: sample on rising edge, msb first
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sh_r <= '0;
      bits_r <= '0;
    end else if (en_i) begin
      if (cs_fall) begin
        bits_r <= '0;
      end else if (sel && sck_rise) begin
        rx_sh_r <= {rx_sh_r[FRAME_BITS-2:0], mosi_s[1]};
        // saturate so an overlong frame still reads as full
        if (bits_r != FRAME_LEN) begin
          bits_r <= bits_r + 5'h01;
        end
      end
    end
  end

  // frame pulses and pin enable
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_r <= 1'b0;
      end_r <= 1'b0;
      miso_oe_b_r <= 1'b1;
    end else if (en_i) begin
      start_r <= cs_fall;
      end_r <= cs_rise;
      miso_oe_b_r <= cs_s[1]; // released while deselected
    end
  end

  assign link.frame_start = start_r;
  assign link.frame_end = end_r;
  assign link.frame_full = (bits_r == FRAME_LEN);
  assign link.rx_word = rx_sh_r;
  assign miso_o = miso_r;
  assign miso_oe_b_o = miso_oe_b_r;

  a_tx_even_parity: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (en_i && cs_fall) |=> (^tx_sh_r == 1'b0))
    else $error("loaded frame has odd parity");

  a_miso_on_fall: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $changed(miso_r) |-> $past(cs_fall || (sel && sck_fall)))
    else $error("miso moved outside a falling edge");
endmodule

/* File: verilog/angle_measure_sleep_control.sv */
module angle_measure_sleep_control #(
  parameter int MEAS_CYCLES = angle_pkg::MEAS_CYC,
  parameter int PWRUP_CYCLES = angle_pkg::PWRUP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic mosi_i,
  input wire logic [angle_pkg::ANGLE_BITS-1:0] angle_sample_i,
  input wire logic alarm_lo_i,
  input wire logic alarm_hi_i,
  output logic miso_o,
  output logic miso_oe_b_o,
  output logic int_b_o,
  output logic int_oe_b_o,
  output logic done_flag_o,
  output logic awake_o
);
  import angle_pkg::*;

  spi_frame_if link ();

  pwr_state_t state_r; // power and measurement phase
  pwr_state_t state_nxt;
  logic [TIMER_BITS-1:0] timer_r; // cycles spent in the current phase
  logic [ADDR_BITS-1:0] angle_r; // alarm hi, alarm lo, angle
  logic [ADDR_BITS-1:0] prev_addr_r; // address of last good command
  logic prev_rd_r; // last good command was a read
  logic wr_data_r; // next frame carries write data
  logic ef_r; // error in an earlier host frame
  logic served_angle_r; // this frame is returning the angle
  logic served_clr_r; // this frame is returning the error clear
  logic int_b_r;
  logic int_oe_b_r;
  logic done_r; // status completion flag
  logic awake_r;
  logic [FRAME_BITS-1:0] rx;
  logic [ADDR_BITS-1:0] tx_data;
  logic cmd_end; // full frame just ended
  logic cmd_ok; // full command frame with good parity
  logic trigger; // read-angle command received
  logic angle_read; // host finished reading the angle
  logic meas_done;
  logic pwrup_done;
  logic done_evt;

  spi_frame_slave u_shift (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .en_i(en_i),
    .sck_i(sck_i),
    .cs_b_i(cs_b_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_b_o(miso_oe_b_o),
    .link(link)
  );

  // command decode at the end of each frame
  assign rx = link.rx_word;
  assign cmd_end = link.frame_end && link.frame_full;
  assign cmd_ok = cmd_end && !wr_data_r && (^rx == 1'b0);
  assign trigger = cmd_ok && rx[BIT_RW] && (rx[ADDR_BITS:1] == ADDR_ANGLE);
  assign angle_read = cmd_end && served_angle_r;
  assign meas_done = (state_r == ST_MEAS) && (timer_r == TIMER_BITS'(MEAS_CYCLES - 1));
  assign pwrup_done = (state_r == ST_POWERUP) && (timer_r == TIMER_BITS'(PWRUP_CYCLES - 1));
  assign done_evt = meas_done || pwrup_done;

  // answer word: data of the previous read, error flag, even parity
  always_comb begin
    tx_data = DATA_ZERO;
    if (prev_rd_r && (prev_addr_r == ADDR_ANGLE)) begin
      tx_data = angle_r;
    end
    link.tx_word = {tx_data, ef_r, ^{tx_data, ef_r}};
  end

  // phase sequencing; no timer ever leaves sleep
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWERUP: begin
        if (pwrup_done) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (trigger) begin
          state_nxt = ST_MEAS;
        end
      end
      ST_MEAS: begin
        // a repeat command mid-measurement is ignored, not restarted
        if (meas_done) begin
          state_nxt = ST_SLEEP;
        end
      end
      default: begin
        state_nxt = ST_SLEEP;
      end
    endcase
  end

  // phase register and its timer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_POWERUP;
      timer_r <= '0;
      awake_r <= 1'b1;
    end else if (en_i) begin
      state_r <= state_nxt;
      awake_r <= (state_nxt != ST_SLEEP);
      if (state_nxt != state_r) begin
        timer_r <= '0;
      end else if (state_r != ST_SLEEP) begin
        timer_r <= timer_r + TIMER_BITS'(1);
      end
    end
  end

  // result capture, one sample per wake, no averaging
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      angle_r <= DATA_ZERO;
    end else if (en_i && done_evt) begin
      angle_r <= {alarm_hi_i, alarm_lo_i, angle_sample_i};
    end
  end

  // interrupt and status flag; a finishing measurement beats a read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_b_r <= 1'b1;
      int_oe_b_r <= 1'b1;
      done_r <= 1'b0;
    end else if (en_i) begin
      if (done_evt) begin
        int_b_r <= 1'b0;
        int_oe_b_r <= 1'b0;
        done_r <= 1'b1;
      end else if (angle_read) begin
        int_b_r <= 1'b1;
        int_oe_b_r <= 1'b1; // released so chained lines can share
        done_r <= 1'b0;
      end
    end
  end

  // command memory for the next answer, and write-data skipping
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_addr_r <= DATA_ZERO;
      prev_rd_r <= 1'b0;
      wr_data_r <= 1'b0;
      served_angle_r <= 1'b0;
      served_clr_r <= 1'b0;
    end else if (en_i) begin
      if (link.frame_start) begin
        served_angle_r <= prev_rd_r && (prev_addr_r == ADDR_ANGLE);
        served_clr_r <= prev_rd_r && (prev_addr_r == ADDR_CLR_ERR);
      end
      if (cmd_end && wr_data_r) begin
        wr_data_r <= 1'b0; // data frame: nothing writable here
      end else if (cmd_ok) begin
        prev_addr_r <= rx[ADDR_BITS:1];
        prev_rd_r <= rx[BIT_RW];
        wr_data_r <= !rx[BIT_RW];
      end
    end
  end

  // error flag: bad parity or short frame sets, clear read resets
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ef_r <= 1'b0;
    end else if (en_i) begin
      if (link.frame_end && (!link.frame_full || (!wr_data_r && ^rx))) begin
        ef_r <= 1'b1; // a new error wins over a clear
      end else if (link.frame_end && served_clr_r) begin
        ef_r <= 1'b0;
      end
    end
  end

  assign int_b_o = int_b_r;
  assign int_oe_b_o = int_oe_b_r;
  assign done_flag_o = done_r;
  assign awake_o = awake_r;

  a_powerup_once: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_r != ST_POWERUP) |=> (state_r != ST_POWERUP))
    else $error("power-up phase re-entered");

  a_done_then_sleep: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (en_i && done_evt) |=> (state_r == ST_SLEEP && !awake_r && !int_b_r))
    else $error("no sleep after conversion done");

  a_read_clears_int: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (en_i && angle_read && !done_evt) |=> (int_b_r && int_oe_b_r && !done_r))
    else $error("interrupt not cleared by angle read");

  a_cmd_wakes: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (en_i && state_r == ST_SLEEP && trigger) |=> (state_r == ST_MEAS && timer_r == '0 && awake_r))
    else $error("read-angle command did not wake");

  a_done_flag_int: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (en_i && meas_done) |=> (!int_b_r && !int_oe_b_r && done_r))
    else $error("completion not flagged");

  a_conv_time: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    ($fell(int_b_r) && $past(state_r) == ST_MEAS)
      |-> ($past(timer_r) == TIMER_BITS'(MEAS_CYCLES - 1)))
    else $error("command to interrupt time wrong");

  a_sleep_holds: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_r == ST_SLEEP && !(en_i && trigger)) |=> (state_r == ST_SLEEP))
    else $error("left sleep without a command");

  a_angle_capture: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (en_i && done_evt) |=> (angle_r == $past({alarm_hi_i, alarm_lo_i, angle_sample_i})))
    else $error("angle not stored at completion");
endmodule

/* File: sim/spi_host_model.sv */
// host side of the serial link: mode 0, frames sent on demand
module spi_host_model (
  output logic sck_o,
  output logic cs_b_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx_word; // answer of the last frame
  event frame_done; // fires once per finished frame
  // idle: deselected, link clock parked low
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one 16-bit frame, msb first, 48 ns link clock, still between frames
  task automatic frame(input logic [15:0] tx);
    int i;
    cs_b_o = 1'b0;
    mosi_o = tx[15];
    #30; // first answer bit needs a few system clocks to appear
    for (i = 15; i >= 0; i--) begin
      rx_word[i] = miso_i;
      sck_o = 1'b1;
      #24;
      sck_o = 1'b0;
      if (i > 0) begin
        mosi_o = tx[i-1];
      end
      #24;
    end
    cs_b_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not keep showing the last bit
    #30; // deselect gap well above the 20 ns minimum
    -> frame_done;
  endtask
endmodule

/* File: sim/angle_measure_sleep_control_tb_top.sv */
// drives frames and samples, notes expected answers, checks timing
module angle_measure_sleep_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MEAS = 50; // shortened measurement, scales the 320-430 us window
  localparam int PWRUP = 400; // longer than one frame so a frame fits in power-up
  localparam int WATCH_NS = 100000; // run needs about a seventh of this
  localparam int FREEZE = 20; // cycles with the clock enable held low
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic en_i = 1'b1; // clock enable, dropped once in mid-measurement
  logic alarm_lo_i = 1'b0;
  logic alarm_hi_i = 1'b0;
  logic [11:0] angle_sample_i = 12'h000;
  logic sck, cs_b, mosi;
  logic miso_o, miso_oe_b_o, int_b_o, int_oe_b_o, done_flag_o, awake_o;
  logic miso_hold = 1'b0; // inverse of last driven bit, shown when released
  wire miso_line = miso_oe_b_o ? miso_hold : miso_o;
  wire int_line = int_oe_b_o ? 1'b1 : int_b_o; // pull-up on the interrupt wire
  logic [31:0] seed = 32'h4641;
  logic [13:0] exp_data, prev;
  logic [31:0] notes[$]; // {mask, expected answer}
  logic [31:0] note;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int mark, n, k, frz, span;
  logic [11:0] zero_pos; // host-held zero reference
  logic [13:0] sum_got, sum_exp; // four-sample sums for host averaging
  always #2.5 clk_i = ~clk_i;
  // free cycle counter and released-line model
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (!miso_oe_b_o) begin
      miso_hold <= ~miso_o;
    end
  end
  spi_host_model host (.sck_o(sck), .cs_b_o(cs_b), .mosi_o(mosi), .miso_i(miso_line));
  angle_measure_sleep_control #(.MEAS_CYCLES(MEAS), .PWRUP_CYCLES(PWRUP)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(en_i), .sck_i(sck), .cs_b_i(cs_b),
    .mosi_i(mosi), .angle_sample_i(angle_sample_i), .alarm_lo_i(alarm_lo_i),
    .alarm_hi_i(alarm_hi_i), .miso_o(miso_o), .miso_oe_b_o(miso_oe_b_o),
    .int_b_o(int_b_o), .int_oe_b_o(int_oe_b_o), .done_flag_o(done_flag_o),
    .awake_o(awake_o));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // data, error flag, then even parity over the upper 15 bits
  function automatic logic [15:0] answer(input logic [13:0] d, input logic ef);
    return {d, ef, ^{d, ef}};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  // new front-end value, held until the next measurement has ended
  task automatic new_sample();
    @(posedge clk_i);
    seed = lfsr_next(seed);
    {alarm_hi_i, alarm_lo_i, angle_sample_i} <= seed[13:0];
    exp_data = seed[13:0];
  endtask
  task automatic send(input logic [15:0] cmd, input logic [15:0] mask, input logic [15:0] exp);
    notes.push_back({mask, exp & mask});
    @(posedge clk_i);
    #1.25; // off every clock edge, so pin changes never race the synchronisers
    host.frame(cmd);
  endtask
  // bounded wait for the interrupt wire to go low
  task automatic wait_int(output int c);
    c = 0;
    while (int_line !== 1'b0 && c < 2000) begin
      @(posedge clk_i);
      c++;
    end
    #1;
  endtask
  // result side: compare every finished frame with the oldest note
  always @(host.frame_done) begin
    note = notes.pop_front();
    check(host.rx_word & note[31:16], note[15:0]);
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(WATCH_NS);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    mark = cyc;
    new_sample();
    #1;
    check({awake_o, int_line, int_oe_b_o, done_flag_o}, 16'h000e);
    // read-angle during power-up: ignored, but selects the angle for the next frame
    send(16'hffff, 16'hffff, answer(14'h0000, 1'b0));
    wait_int(n);
    check(16'(cyc - mark >= PWRUP && cyc - mark <= PWRUP + 2), 16'h0001);
    check({awake_o, int_line, int_oe_b_o, done_flag_o}, 16'h0001);
    tick(3 * MEAS);
    check({awake_o, int_line, done_flag_o}, 16'h0001);
    // host polls at its own rate; each poll clears, wakes and remeasures
    zero_pos = exp_data[11:0];
    sum_got = 14'h0000;
    sum_exp = 14'h0000;
    for (k = 0; k < 4; k++) begin
      prev = exp_data;
      new_sample();
      send(16'hffff, 16'hffff, answer(prev, 1'b0));
      // host subtracts its own zero and averages four readings
      sum_got = sum_got + {2'h0, 12'(host.rx_word[13:2] - zero_pos)};
      sum_exp = sum_exp + {2'h0, 12'(prev[11:0] - zero_pos)};
      mark = cyc;
      frz = 0;
      tick(4);
      check({awake_o, int_line, int_oe_b_o, done_flag_o}, 16'h000e);
      if (k == 1) begin
        // enable low mid-measurement: all state holds, so the wait stretches
        @(posedge clk_i);
        en_i <= 1'b0;
        repeat (FREEZE) @(posedge clk_i);
        en_i <= 1'b1;
        #1;
        frz = FREEZE;
        check({awake_o, int_line, done_flag_o}, 16'h0006);
      end
      wait_int(n);
      span = cyc - mark - frz;
      check(16'(span >= MEAS - 5 && span <= MEAS + 6), 16'h0001);
      check({awake_o, done_flag_o}, 16'h0001);
    end
    check({4'h0, sum_got[13:2]}, {4'h0, sum_exp[13:2]});
    // bad parity: flagged and ignored, yet the angle answer clears the interrupt
    prev = exp_data;
    new_sample();
    send(16'hfffe, 16'hffff, answer(prev, 1'b0));
    tick(8);
    check({awake_o, int_line}, 16'h0001);
    send(16'he700, 16'hffff, answer(prev, 1'b1));
    send(16'hffff, 16'hffff, answer(14'h0000, 1'b1));
    wait_int(n);
    check(16'(n < 2000), 16'h0001);
    send(16'hffff, 16'hffff, answer(exp_data, 1'b0));
    wait_int(n);
    check(16'(n < 2000), 16'h0001);
    // write command: its data frame is skipped, parity unchecked, no error raised
    send(16'h0000, 16'hffff, answer(exp_data, 1'b0));
    send(16'h0001, 16'hffff, answer(14'h0000, 1'b0));
    send(16'hffff, 16'hffff, answer(14'h0000, 1'b0));
    wait_int(n);
    check(16'(n < 2000), 16'h0001);
    tick(2);
    give_verdict();
  end
endmodule
